// ### rtl/cgcr_pkg.sv
// Summary of operation
// - Three-bit strength codes, all ones strongest; byte 13 holds PCI 7:5, USB 4:2.
// - Single-ended group strength is a three-bit code in byte 14 bits 7:5.
// - SATA clock spreads while spread enable is one, its reset value; else unspread.
// - At power-up the strap pin loads the mode bits; release bit resets to one.
// - After release bit is written zero, writes with latches open overwrite strap bits.
// - Overwritable: byte0 bit2, byte1 bits 6,4,3, byte9 bit1, byte11 bit5.
// - Software stop bit zero stops stoppable outputs synchronously, no short pulse.
// - Software stop bit one, its reset value, restarts stopped outputs without short pulse.
// - Multiplier nine bits: byte 15 plus byte 16 bit 7; divider byte 16 bits 6:0.
// - Programmed multiplier and divider affect the CPU clock only while enabled.
// - Programmable CPU enable is byte 18 bit 4, reset zero.
// - Enabled CPU frequency is gear constant times multiplier divided by divider.
`default_nettype none
package cgcr_pkg;
    localparam logic [7:0] OFS_STRAP_B0   = 8'h00;
    localparam logic [7:0] OFS_STRAP_B1   = 8'h01;
    localparam logic [7:0] OFS_STRAP_B9   = 8'h09;
    localparam logic [7:0] OFS_STRAP_B11  = 8'h0b;
    localparam logic [7:0] OFS_BYTE_COUNT = 8'h0c;
    localparam logic [7:0] OFS_DRIVE      = 8'h0d;
    localparam logic [7:0] OFS_CONTROL    = 8'h0e;
    localparam logic [7:0] OFS_MULT_LOW   = 8'h0f;
    localparam logic [7:0] OFS_MULT_DIV   = 8'h10;
    localparam logic [7:0] OFS_PROG_EN    = 8'h12;

    localparam logic [5:0] RST_BYTE_COUNT = 6'h13;
    localparam logic [7:0] RST_DRIVE      = 8'h48;
    localparam logic [2:0] RST_SE         = 3'h2;
    localparam logic       RST_SATA       = 1'b1;
    localparam logic       RST_RELEASE    = 1'b1;
    localparam logic       RST_SW_STOP    = 1'b1;

    // Byte 14, 16 and 18 field positions
    localparam int B14_SE_LSB  = 5;
    localparam int B14_SATA    = 2;
    localparam int B14_RELEASE = 1;
    localparam int B14_SW_STOP = 0;
    localparam int B16_N8      = 7;
    localparam int B18_PROG    = 4;
    // Strap bit positions inside their bytes
    localparam int SB_B0  = 2;
    localparam int SB_B1A = 6;
    localparam int SB_B1B = 4;
    localparam int SB_B1C = 3;
    localparam int SB_B9  = 1;
    localparam int SB_B11 = 5;

    typedef struct packed {
        logic [2:0] pci;
        logic [2:0] usb;
        logic       ref_bit2;
        logic       ref_bit0;
        logic [2:0] single_ended;
    } cgcr_drive_t;
endpackage : cgcr_pkg
`default_nettype wire

// ### rtl/cgcr_regs.sv
`default_nettype none
module cgcr_regs
    import cgcr_pkg::*;
#(
    parameter int MULT_W = 9,
    parameter int DIV_W  = 7
) (
    input  wire logic              clock,
    input  wire logic              reset_n,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    input  wire logic [7:0]        reg_addr,
    input  wire logic [7:0]        reg_wdata,
    output var  logic [7:0]        reg_rdata_q,
    output var  logic              reg_rvalid_q,
    input  wire logic              config_strap_pin,
    input  wire logic              latches_open,
    input  wire logic              out_low_phase,
    output var  logic [5:0]        strap_bits_q,
    output var  cgcr_drive_t       drive_q,
    output var  logic              sata_spread_enable_q,
    output var  logic              stoppable_run_q,
    output var  logic              cpu_prog_enable_q,
    output var  logic [MULT_W-1:0] cpu_freq_multiplier_q,
    output var  logic [DIV_W-1:0]  cpu_freq_divider_q
);
    if (MULT_W != 9 || DIV_W != 7) begin : g_width_check
        $error("cgcr_regs: multiplier must be 9 bits and divider 7 bits");
    end

    logic       rst_a_q;
    logic       rst_q;
    logic       strap_done_q;
    logic [5:0] bc_q;
    logic       sw_stop_q;
    logic       release_q;
    logic [7:0] n_low_q;
    logic       n_high_q;
    logic [6:0] m_q;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rst_a_q <= 1'b0;
            rst_q   <= 1'b0;
        end else begin
            rst_a_q <= 1'b1;
            rst_q   <= rst_a_q;
        end
    end

    wire logic wr_bc    = reg_wr && reg_addr == OFS_BYTE_COUNT;
    wire logic wr_drive = reg_wr && reg_addr == OFS_DRIVE;
    wire logic wr_ctl   = reg_wr && reg_addr == OFS_CONTROL;
    wire logic wr_nlo   = reg_wr && reg_addr == OFS_MULT_LOW;
    wire logic wr_ndiv  = reg_wr && reg_addr == OFS_MULT_DIV;
    wire logic wr_prog  = reg_wr && reg_addr == OFS_PROG_EN;
    // Strap overwrite only while released and the latches are still open
    wire logic strap_wr_ok = strap_done_q && !release_q && latches_open;
    wire logic wr_s0  = strap_wr_ok && reg_wr && reg_addr == OFS_STRAP_B0;
    wire logic wr_s1  = strap_wr_ok && reg_wr && reg_addr == OFS_STRAP_B1;
    wire logic wr_s9  = strap_wr_ok && reg_wr && reg_addr == OFS_STRAP_B9;
    wire logic wr_s11 = strap_wr_ok && reg_wr && reg_addr == OFS_STRAP_B11;

    wire logic [7:0] ctl_rd = {drive_q.single_ended, 2'b00, sata_spread_enable_q,
                               release_q, sw_stop_q};
    wire logic [7:0] drive_rd = {drive_q.pci, drive_q.usb, drive_q.ref_bit2,
                                 drive_q.ref_bit0};

    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = 8'h00;
        case (reg_addr)
            OFS_BYTE_COUNT: rd_mux = {2'b00, bc_q};
            OFS_DRIVE:      rd_mux = drive_rd;
            OFS_CONTROL:    rd_mux = ctl_rd;
            OFS_MULT_LOW:   rd_mux = n_low_q;
            OFS_MULT_DIV:   rd_mux = {n_high_q, m_q};
            OFS_PROG_EN:    rd_mux = {3'b000, cpu_prog_enable_q, 4'h0};
            default:        rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clock or negedge rst_q) begin
        if (!rst_q) begin
            reg_rdata_q  <= 8'h00;
            reg_rvalid_q <= 1'b0;
        end else begin
            reg_rdata_q  <= reg_rd ? rd_mux : reg_rdata_q;
            reg_rvalid_q <= reg_rd;
        end
    end

    // Strap is sampled after reset release, never inside the async branch
    always_ff @(posedge clock or negedge rst_q) begin
        if (!rst_q) begin
            strap_done_q <= 1'b0;
            strap_bits_q <= 6'h00;
        end else if (!strap_done_q) begin
            strap_done_q <= 1'b1;
            strap_bits_q <= {6{config_strap_pin}};
        end else begin
            if (wr_s0) strap_bits_q[0] <= reg_wdata[SB_B0];
            if (wr_s1) begin
                strap_bits_q[1] <= reg_wdata[SB_B1A];
                strap_bits_q[2] <= reg_wdata[SB_B1B];
                strap_bits_q[3] <= reg_wdata[SB_B1C];
            end
            if (wr_s9)  strap_bits_q[4] <= reg_wdata[SB_B9];
            if (wr_s11) strap_bits_q[5] <= reg_wdata[SB_B11];
        end
    end

    always_ff @(posedge clock or negedge rst_q) begin
        if (!rst_q) begin
            bc_q                 <= RST_BYTE_COUNT;
            drive_q              <= {RST_DRIVE, RST_SE};
            sata_spread_enable_q <= RST_SATA;
            release_q            <= RST_RELEASE;
            sw_stop_q            <= RST_SW_STOP;
        end else begin
            if (wr_bc) bc_q <= reg_wdata[5:0];
            if (wr_drive) begin
                drive_q.pci      <= reg_wdata[7:5];
                drive_q.usb      <= reg_wdata[4:2];
                drive_q.ref_bit2 <= reg_wdata[1];
                drive_q.ref_bit0 <= reg_wdata[0];
            end
            if (wr_ctl) begin
                drive_q.single_ended <= reg_wdata[B14_SE_LSB +: 3];
                sata_spread_enable_q <= reg_wdata[B14_SATA];
                release_q            <= reg_wdata[B14_RELEASE];
                sw_stop_q            <= reg_wdata[B14_SW_STOP];
            end
        end
    end

    // Gate moves only in the outputs' low phase so no pulse is cut short
    always_ff @(posedge clock or negedge rst_q) begin
        if (!rst_q) begin
            stoppable_run_q <= RST_SW_STOP;
        end else if (out_low_phase) begin
            stoppable_run_q <= sw_stop_q;
        end
    end

    always_ff @(posedge clock or negedge rst_q) begin
        if (!rst_q) begin
            n_low_q           <= 8'h00;
            n_high_q          <= 1'b0;
            m_q               <= 7'h00;
            cpu_prog_enable_q <= 1'b0;
        end else begin
            if (wr_nlo) n_low_q <= reg_wdata;
            if (wr_ndiv) begin
                n_high_q <= reg_wdata[B16_N8];
                m_q      <= reg_wdata[6:0];
            end
            if (wr_prog) cpu_prog_enable_q <= reg_wdata[B18_PROG];
        end
    end

    // The PLL scales its gear constant by these; zero means hold the table ratio.
    // A divider change lands with its own byte, so the host pairs it with the
    // multiplier low byte in the write just before it; each byte applies one cycle after it lands, so a brief transient ratio remains.
    always_ff @(posedge clock or negedge rst_q) begin
        if (!rst_q) begin
            cpu_freq_multiplier_q <= '0;
            cpu_freq_divider_q    <= '0;
        end else begin
            cpu_freq_multiplier_q <= cpu_prog_enable_q ? {n_high_q, n_low_q} : 9'h000;
            cpu_freq_divider_q    <= cpu_prog_enable_q ? m_q : 7'h00;
        end
    end

    // Read port: one answer a cycle after each strobe, data held between reads
    read_answer_a: assert property (@(posedge clock) disable iff (!rst_q)
        reg_rd |=> reg_rvalid_q ##1 !reg_rvalid_q || $past(reg_rd))
        else $error("read answer not one cycle after request");

    rvalid_idle_a: assert property (@(posedge clock) disable iff (!rst_q)
        !reg_rd |=> !reg_rvalid_q)
        else $error("read answer without request");

    read_hold_a: assert property (@(posedge clock) disable iff (!rst_q)
        !reg_rd |=> $stable(reg_rdata_q))
        else $error("read data moved without a read");

    bc_reserved_a: assert property (@(posedge clock) disable iff (!rst_q)
        (reg_rd && reg_addr == OFS_BYTE_COUNT) |=> reg_rdata_q[7:6] == 2'b00)
        else $error("byte count reserved bits not zero");

    ctl_reserved_a: assert property (@(posedge clock) disable iff (!rst_q)
        (reg_rd && reg_addr == OFS_CONTROL) |=> reg_rdata_q[4:3] == 2'b00)
        else $error("control reserved bits not zero");

    prog_reserved_a: assert property (@(posedge clock) disable iff (!rst_q)
        (reg_rd && reg_addr == OFS_PROG_EN) |=> reg_rdata_q[7:5] == 3'b000
                                                && reg_rdata_q[3:0] == 4'h0)
        else $error("enable byte reserved bits not zero");

    strap_read_a: assert property (@(posedge clock) disable iff (!rst_q)
        (reg_rd && reg_addr == OFS_STRAP_B1) |=> reg_rdata_q == 8'h00)
        else $error("strap byte read back not zero");

    bc_write_a: assert property (@(posedge clock) disable iff (!rst_q)
        wr_bc |=> bc_q == $past(reg_wdata[5:0]))
        else $error("byte count did not take written value");

    drive_write_a: assert property (@(posedge clock) disable iff (!rst_q)
        wr_drive |=> drive_q.pci == $past(reg_wdata[7:5])
                     && drive_q.usb == $past(reg_wdata[4:2]))
        else $error("strength codes did not take written value");

    drive_hold_a: assert property (@(posedge clock) disable iff (!rst_q)
        !wr_drive |=> $stable(drive_q.pci) && $stable(drive_q.usb))
        else $error("strength codes moved without a write");

    se_write_a: assert property (@(posedge clock) disable iff (!rst_q)
        wr_ctl |=> drive_q.single_ended == $past(reg_wdata[B14_SE_LSB +: 3]))
        else $error("single-ended strength did not take written value");

    sata_write_a: assert property (@(posedge clock) disable iff (!rst_q)
        wr_ctl |=> sata_spread_enable_q == $past(reg_wdata[B14_SATA]))
        else $error("spread enable did not take written value");

    sata_hold_a: assert property (@(posedge clock) disable iff (!rst_q)
        !wr_ctl |=> $stable(sata_spread_enable_q))
        else $error("spread enable moved without a write");

    // Mode bits: loaded once from the strap, then only through the open window
    strap_capture_a: assert property (@(posedge clock) disable iff (!rst_q)
        !strap_done_q |=> strap_bits_q == {6{$past(config_strap_pin)}})
        else $error("mode bits not loaded from strap");

    release_write_a: assert property (@(posedge clock) disable iff (!rst_q)
        wr_ctl |=> release_q == $past(reg_wdata[B14_RELEASE]))
        else $error("release bit did not take written value");

    strap_lock_a: assert property (@(posedge clock) disable iff (!rst_q)
        ($past(strap_done_q) && $past(release_q)) |-> $stable(strap_bits_q))
        else $error("strap bits changed while locked");

    strap_open_a: assert property (@(posedge clock) disable iff (!rst_q)
        ($past(strap_done_q) && !$past(latches_open)) |-> $stable(strap_bits_q))
        else $error("strap bits changed with latches closed");

    strap_b0_a: assert property (@(posedge clock) disable iff (!rst_q)
        wr_s0 |=> strap_bits_q[0] == $past(reg_wdata[SB_B0]))
        else $error("byte 0 mode bit not overwritten");

    strap_b1_a: assert property (@(posedge clock) disable iff (!rst_q)
        wr_s1 |=> strap_bits_q[3:1] == {$past(reg_wdata[SB_B1C]), $past(reg_wdata[SB_B1B]),
                                        $past(reg_wdata[SB_B1A])})
        else $error("byte 1 mode bits not overwritten");

    strap_b9_a: assert property (@(posedge clock) disable iff (!rst_q)
        wr_s9 |=> strap_bits_q[4] == $past(reg_wdata[SB_B9]))
        else $error("byte 9 mode bit not overwritten");

    strap_b11_a: assert property (@(posedge clock) disable iff (!rst_q)
        wr_s11 |=> strap_bits_q[5] == $past(reg_wdata[SB_B11]))
        else $error("byte 11 mode bit not overwritten");

    stop_write_a: assert property (@(posedge clock) disable iff (!rst_q)
        wr_ctl |=> sw_stop_q == $past(reg_wdata[B14_SW_STOP]))
        else $error("software stop bit did not take written value");

    stop_phase_a: assert property (@(posedge clock) disable iff (!rst_q)
        $changed(stoppable_run_q) |-> $past(out_low_phase))
        else $error("output gate moved outside low phase");

    stop_apply_a: assert property (@(posedge clock) disable iff (!rst_q)
        (out_low_phase && !sw_stop_q) |=> !stoppable_run_q)
        else $error("stoppable outputs not stopped");

    stop_follow_a: assert property (@(posedge clock) disable iff (!rst_q)
        (out_low_phase && sw_stop_q) |=> stoppable_run_q)
        else $error("stopped outputs not resumed");

    mult_write_a: assert property (@(posedge clock) disable iff (!rst_q)
        (wr_nlo && cpu_prog_enable_q && !wr_prog) |=> ##1
            cpu_freq_multiplier_q[7:0] == $past(reg_wdata, 2))
        else $error("multiplier low byte not applied");

    div_write_a: assert property (@(posedge clock) disable iff (!rst_q)
        wr_ndiv |=> m_q == $past(reg_wdata[6:0]) && n_high_q == $past(reg_wdata[B16_N8]))
        else $error("divider byte did not take written value");

    prog_gate_a: assert property (@(posedge clock) disable iff (!rst_q)
        !$past(cpu_prog_enable_q) |-> cpu_freq_multiplier_q == 9'h000
                                      && cpu_freq_divider_q == 7'h00)
        else $error("programmed ratio applied while disabled");

    prog_write_a: assert property (@(posedge clock) disable iff (!rst_q)
        wr_prog |=> cpu_prog_enable_q == $past(reg_wdata[B18_PROG]))
        else $error("programmable enable did not take written value");

    prog_apply_a: assert property (@(posedge clock) disable iff (!rst_q)
        cpu_prog_enable_q |=> cpu_freq_multiplier_q == {$past(n_high_q), $past(n_low_q)}
                              && cpu_freq_divider_q == $past(m_q))
        else $error("programmed ratio not applied while enabled");
endmodule : cgcr_regs
`default_nettype wire

// ### tb/cgcr_host.sv
`default_nettype none
module cgcr_host (
    input  wire logic       clock,
    input  wire logic [7:0] reg_rdata_q,
    input  wire logic       reg_rvalid_q,
    output var  logic       reg_wr,
    output var  logic       reg_rd,
    output var  logic [7:0] reg_addr,
    output var  logic [7:0] reg_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    // Idle data is inverted so a stale byte can never pass as a fresh one
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clock);
        reg_wr = 1'b0;
        reg_wdata = ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
        @(negedge clock);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge clock);
        reg_rd = 1'b0;
        for (int i = 0; i < 4 && reg_rvalid_q !== 1'b1; i++) @(negedge clock);
        ok = (reg_rvalid_q === 1'b1);
        d = reg_rdata_q;
    endtask : rd
endmodule : cgcr_host
`default_nettype wire

// ### tb/testbench.sv
`default_nettype none
module testbench
    import cgcr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock = 1'b0;
    logic        reset_n = 1'b0;
    logic        strap = 1'b1;
    logic        lopen = 1'b0;
    logic        lowph = 1'b1;
    logic        wr, rd, rv, sata, run, prog;
    logic [7:0]  addr, wdata, rdata, ra;
    logic [5:0]  strap_q;
    cgcr_drive_t drv;
    logic [8:0]  mul;
    logic [6:0]  dv;
    logic [7:0]  m [0:18];
    logic [7:0]  tab [6] = '{8'h0c, 8'h0d, 8'h0e, 8'h0f, 8'h10, 8'h12};
    logic [7:0]  sa [4] = '{8'h00, 8'h01, 8'h09, 8'h0b};
    logic [7:0]  sd [4] = '{8'h00, 8'h10, 8'h00, 8'h00};
    logic [5:0]  se [4] = '{6'h3e, 6'h34, 6'h24, 6'h04};
    int          n_fail = 0;
    int          num_checks = 0;
    always #5 clock = ~clock;
    cgcr_regs DUT (.clock(clock), .reset_n(reset_n), .reg_wr(wr), .reg_rd(rd),
        .reg_addr(addr), .reg_wdata(wdata), .reg_rdata_q(rdata), .reg_rvalid_q(rv),
        .config_strap_pin(strap), .latches_open(lopen), .out_low_phase(lowph),
        .strap_bits_q(strap_q), .drive_q(drv), .sata_spread_enable_q(sata),
        .stoppable_run_q(run), .cpu_prog_enable_q(prog),
        .cpu_freq_multiplier_q(mul), .cpu_freq_divider_q(dv));
    cgcr_host host (.clock(clock), .reg_rdata_q(rdata), .reg_rvalid_q(rv),
        .reg_wr(wr), .reg_rd(rd), .reg_addr(addr), .reg_wdata(wdata));
    task automatic results();
        if (n_fail == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : results
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    function automatic logic [7:0] msk(input logic [7:0] a);
        case (a)
            8'h0c: return 8'h3f;
            8'h0d, 8'h0f, 8'h10: return 8'hff;
            8'h0e: return 8'he7;
            8'h12: return 8'h10;
            default: return 8'h00;
        endcase
    endfunction : msk
    task automatic wrm(input logic [7:0] a, input logic [7:0] d);
        host.wr(a, d);
        if (a <= 8'h12) m[a] = d & msk(a);
    endtask : wrm
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        logic       ok;
        host.rd(a, d, ok);
        if (!ok) begin
            n_fail++;
            results();
        end else begin
            chk(16'(d), 16'(e));
        end
    endtask : rdchk
    task automatic mreset();
        m = '{default: 8'h00};
        m[12] = 8'h13;
        m[13] = 8'h48;
        m[14] = 8'h47;
    endtask : mreset
    // Applied values land two edges after the write, so settle before looking
    task automatic chk_out();
        repeat (2) @(negedge clock);
        chk(16'(drv), 16'({m[13], m[14][7:5]}));
        chk(16'(sata), 16'(m[14][2]));
        chk(16'(run), 16'(m[14][0]));
        chk(16'(prog), 16'(m[18][4]));
        chk(16'(mul), m[18][4] ? {7'h00, m[16][7], m[15]} : 16'h0000);
        chk(16'(dv), m[18][4] ? {9'h000, m[16][6:0]} : 16'h0000);
    endtask : chk_out
    initial begin
        mreset();
        void'($urandom(10));
        repeat (2) @(negedge clock);
        reset_n = 1'b1;
        repeat (4) @(negedge clock);
        chk(16'(strap_q), 16'h003f);
        for (int a = 12; a <= 18; a++) rdchk(8'(a), m[a]);
        chk_out();
        lopen = 1'b1;
        host.wr(8'h00, 8'h00);
        chk(16'(strap_q), 16'h003f);
        wrm(8'h0e, 8'h45);
        foreach (sa[i]) begin
            host.wr(sa[i], sd[i]);
            chk(16'(strap_q), 16'(se[i]));
        end
        lopen = 1'b0;
        host.wr(8'h00, 8'h04);
        chk(16'(strap_q), 16'h0004);
        lowph = 1'b0;
        wrm(8'h0e, 8'h44);
        repeat (3) @(negedge clock);
        chk(16'(run), 16'h0001);
        lowph = 1'b1;
        chk_out();
        wrm(8'h0e, 8'h45);
        chk_out();
        for (int i = 0; i < 40; i++) begin
            ra = tab[$urandom_range(5, 0)];
            if (ra == 8'h10) wrm(8'h0f, 8'($urandom));
            wrm(ra, 8'($urandom));
            rdchk(ra, m[ra]);
            chk_out();
        end
        wrm(8'h12, 8'h10);
        wrm(8'h0f, 8'h5a);
        wrm(8'h10, 8'hc3);
        chk_out();
        wrm(8'h11, 8'hff);
        rdchk(8'h11, 8'h00);
        rdchk(8'h00, 8'h00);
        // Second reset with the strap low: mode bits and every register reload
        reset_n = 1'b0;
        strap = 1'b0;
        mreset();
        repeat (2) @(negedge clock);
        reset_n = 1'b1;
        repeat (4) @(negedge clock);
        chk(16'(strap_q), 16'h0000);
        for (int a = 12; a <= 18; a++) rdchk(8'(a), m[a]);
        chk_out();
        results();
    end
endmodule : testbench
`default_nettype wire
